// File: core/eib_defs.svh
// Register map, fields, resets and timing.
// Assumes a 100 MHz core clock; byte address is four times the index.
`ifndef EIB_DEFS_SVH
`define EIB_DEFS_SVH

// Register indices
`define EIB_IDX_POLICY     8'h08
`define EIB_IDX_SRC_FIRST  8'h09
`define EIB_IDX_DST_FIRST  8'h0A
`define EIB_IDX_SRC_SECOND 8'h0B
`define EIB_IDX_DST_SECOND 8'h0C
`define EIB_IDX_BRIDGE     8'h0D
`define EIB_IDX_DET_LIMIT  8'h0F
`define EIB_IDX_DET_COUNT  8'h10
`define EIB_IDX_COR_LIMIT  8'h11
`define EIB_IDX_COR_COUNT  8'h12
`define EIB_IDX_IRQ_STAT   8'h20
`define EIB_IDX_IRQ_MASK   8'h21

// Field positions
`define EIB_POL_AUTOCLR_BIT 2
`define EIB_POL_SEL_LSB     0
`define EIB_ADDR_LSB        1
`define EIB_BR_LOCACK_BIT   7
`define EIB_BR_SH_LSB       5
`define EIB_BR_RATE_LSB     2

// Reset values
`define EIB_RST_AUTOCLR 1'b0
`define EIB_RST_SEL     2'h0
`define EIB_RST_ADDR    7'h00
`define EIB_RST_LOCACK  1'b1
`define EIB_RST_SH      2'h1
`define EIB_RST_RATE    3'h5
`define EIB_RST_BYTE    8'h00

// Timing
`define EIB_CLK_MHZ        100
`define EIB_NS_UP(ns)      ((((ns) * `EIB_CLK_MHZ) + 999) / 1000)
`define EIB_AUTOCLR_US     1
`define EIB_AUTOCLR_CYC    (`EIB_AUTOCLR_US * `EIB_CLK_MHZ)
`define EIB_SH0_SETUP_NS   352
`define EIB_SH0_HOLD_NS    117
`define EIB_SH1_SETUP_NS   469
`define EIB_SH1_HOLD_NS    234
`define EIB_SH2_SETUP_NS   938
`define EIB_SH2_HOLD_NS    352
`define EIB_SH3_SETUP_NS   1046
`define EIB_SH3_HOLD_NS    469

`endif

// File: core/eib_err_judge.sv
// Error output judge and timed counter clear.
// Assumes registered counts and limits.
`include "eib_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module eib_err_judge
    import eib_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // Policy
    input  wire logic       auto_clear,
    input  wire logic [1:0] err_sel,
    // Counts and limits
    input  wire logic [7:0] det_cnt,
    input  wire logic [7:0] det_lim,
    input  wire logic [7:0] cor_cnt,
    input  wire logic [7:0] cor_lim,
    // Results
    output logic            err_q,
    output logic            clear_q
);

    eib_judge_t s_q;
    eib_judge_t s_d;
    logic       det_over;
    logic       cor_over;
    logic       err_now;

    always_comb begin
        s_d      = s_q;
        det_over = det_cnt > det_lim;
        cor_over = cor_cnt > cor_lim;
        case (err_sel)
            2'h0: err_now = det_over;
            2'h1: err_now = cor_over;
            default: err_now = det_over | cor_over;
        endcase
        s_d.err   = err_now;
        s_d.clear = 1'b0;
        case (s_q.state)
            EIB_ERR_QUIET: begin
                // Timer starts at the error rise
                if (err_now && !s_q.err && auto_clear) begin
                    s_d.state = EIB_ERR_WAIT;
                    s_d.timer = 8'h01;
                end else if (err_now) begin
                    s_d.state = EIB_ERR_HELD;
                end
            end
            EIB_ERR_WAIT: begin
                if (!auto_clear) begin
                    s_d.state = EIB_ERR_HELD;
                end else if (s_q.timer == 8'(`EIB_AUTOCLR_CYC)) begin
                    s_d.clear = 1'b1;
                    s_d.state = EIB_ERR_QUIET;
                end else begin
                    s_d.timer = s_q.timer + 8'h01;
                end
            end
            EIB_ERR_HELD: begin
                // Rearm once quiet
                if (!err_now) begin
                    s_d.state = EIB_ERR_QUIET;
                end
            end
            default: s_d.state = EIB_ERR_QUIET;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= '{state: EIB_ERR_QUIET, timer: 8'h00, err: 1'b0, clear: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign err_q   = s_q.err;
    assign clear_q = s_q.clear;

endmodule

`default_nettype wire

// File: core/eib_pkg.sv
// Shared types.
// Numbers live in eib_defs.svh.
package eib_pkg;

    typedef struct packed {
        logic [6:0] src;
        logic [6:0] dst;
    } eib_xlate_pair_t;

    typedef struct packed {
        logic       local_ack;
        logic [1:0] sh_sel;
        logic [2:0] rate_sel;
    } eib_bridge_cfg_t;

    typedef enum logic [1:0] {
        EIB_ERR_QUIET,
        EIB_ERR_WAIT,
        EIB_ERR_HELD
    } eib_err_state_t;

    typedef struct packed {
        eib_err_state_t state;
        logic [7:0]     timer;
        logic           err;
        logic           clear;
    } eib_judge_t;

    typedef struct packed {
        logic       valid;
        logic       hit;
        logic [6:0] addr;
    } eib_xlate_out_t;

    typedef struct packed {
        logic            auto_clear;
        logic [1:0]      err_sel;
        eib_xlate_pair_t pair_a;
        eib_xlate_pair_t pair_b;
        eib_bridge_cfg_t bridge;
        logic [7:0]      det_lim;
        logic [7:0]      cor_lim;
        logic [7:0]      det_cnt;
        logic [7:0]      cor_cnt;
        logic [1:0]      irq_stat;
        logic [1:0]      irq_mask;
        logic            irq;
        logic            err_prev;
        logic            ap_write;
        logic [7:0]      ap_idx;
        logic [31:0]     rdata;
        logic            hreadyout;
        logic            hresp;
        logic            slave_ack;
        logic [6:0]      setup_cyc;
        logic [6:0]      hold_cyc;
        logic [2:0]      rate_sel;
    } eib_regs_t;

endpackage

// File: core/eib_regs.sv
// Error policy and I2C bridge registers behind AHB-Lite.
// Assumes one master and one-cycle error pulses.
//
// What this block does
// - Auto-clear off leaves counters and error output alone.
// - Auto-clear on clears both counters 1 us after the error output rises.
// - Select 00: error output while detected count exceeds its limit.
// - Select 01: error output while corrected count exceeds its limit.
// - Select 10 or 11: error output while either count exceeds its limit.
// - Two 8-bit limits, each compared with a read-only 8-bit counter.
// - First translation pair: 7-bit source and destination in bits 7:1, bit 0 zero.
// - Second translation pair: same layout, zero reset.
// - Local acknowledge off: no acknowledge without forward channel.
// - Local acknowledge on: acknowledge even without forward channel.
// - A 2-bit field picks one of four slave setup/hold times.
// - A 3-bit field picks the master bit rate.
`include "eib_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module eib_regs
    import eib_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Error events from the link decoder
    input  wire logic        det_err_evt,
    input  wire logic        cor_err_evt,
    output logic             err_out,
    output logic             irq,
    // Bridge address path
    input  wire logic        fwd_req_valid,
    input  wire logic [6:0]  fwd_req_addr,
    output logic             fwd_out_valid,
    output logic             fwd_out_hit,
    output logic [6:0]       fwd_out_addr,
    // Bridge slave and master settings
    input  wire logic        fwd_chan_up,
    output logic             slave_ack_allow,
    output logic [6:0]       slave_setup_cyc,
    output logic [6:0]       slave_hold_cyc,
    output logic [2:0]       master_bit_rate_sel
);

    localparam logic [7:0] CNT_MAX = 8'hFF;

    eib_regs_t      s_q;
    eib_regs_t      s_d;
    logic           judge_err;
    logic           judge_clear;
    eib_xlate_out_t xl_out;
    logic           ap_take;
    logic [7:0]     ap_idx_now;
    logic [7:0]     wbyte;
    logic [1:0]     irq_evt;
    logic           stat_rd;

    // Setup and hold counts in core cycles, rounded up
    function automatic logic [13:0] sh_cycles(input logic [1:0] sel);
        case (sel)
            2'h0: sh_cycles = {7'(`EIB_NS_UP(`EIB_SH0_SETUP_NS)), 7'(`EIB_NS_UP(`EIB_SH0_HOLD_NS))};
            2'h1: sh_cycles = {7'(`EIB_NS_UP(`EIB_SH1_SETUP_NS)), 7'(`EIB_NS_UP(`EIB_SH1_HOLD_NS))};
            2'h2: sh_cycles = {7'(`EIB_NS_UP(`EIB_SH2_SETUP_NS)), 7'(`EIB_NS_UP(`EIB_SH2_HOLD_NS))};
            default: sh_cycles = {7'(`EIB_NS_UP(`EIB_SH3_SETUP_NS)),
                                  7'(`EIB_NS_UP(`EIB_SH3_HOLD_NS))};
        endcase
    endfunction

    // Unmapped reads as zero
    function automatic logic [7:0] read_byte(input logic [7:0] idx, input eib_regs_t s);
        case (idx)
            `EIB_IDX_POLICY:     read_byte = {5'h00, s.auto_clear, s.err_sel};
            `EIB_IDX_SRC_FIRST:  read_byte = {s.pair_a.src, 1'b0};
            `EIB_IDX_DST_FIRST:  read_byte = {s.pair_a.dst, 1'b0};
            `EIB_IDX_SRC_SECOND: read_byte = {s.pair_b.src, 1'b0};
            `EIB_IDX_DST_SECOND: read_byte = {s.pair_b.dst, 1'b0};
            `EIB_IDX_BRIDGE:     read_byte = {s.bridge.local_ack, s.bridge.sh_sel,
                                              s.bridge.rate_sel, 2'h0};
            `EIB_IDX_DET_LIMIT:  read_byte = s.det_lim;
            `EIB_IDX_DET_COUNT:  read_byte = s.det_cnt;
            `EIB_IDX_COR_LIMIT:  read_byte = s.cor_lim;
            `EIB_IDX_COR_COUNT:  read_byte = s.cor_cnt;
            `EIB_IDX_IRQ_STAT:   read_byte = {6'h00, s.irq_stat};
            `EIB_IDX_IRQ_MASK:   read_byte = {6'h00, s.irq_mask};
            default:             read_byte = 8'h00;
        endcase
    endfunction

    eib_err_judge u_judge (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .auto_clear (s_q.auto_clear),
        .err_sel    (s_q.err_sel),
        .det_cnt    (s_q.det_cnt),
        .det_lim    (s_q.det_lim),
        .cor_cnt    (s_q.cor_cnt),
        .cor_lim    (s_q.cor_lim),
        .err_q      (judge_err),
        .clear_q    (judge_clear)
    );

    eib_xlate u_xlate (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .pair_a    (s_q.pair_a),
        .pair_b    (s_q.pair_b),
        .req_valid (fwd_req_valid),
        .req_addr  (fwd_req_addr),
        .out_q     (xl_out)
    );

    always_comb begin
        s_d        = s_q;
        ap_take    = hsel & htrans[1] & hready;
        ap_idx_now = haddr[9:2];
        wbyte      = hwdata[7:0];
        stat_rd    = ap_take & ~hwrite & (ap_idx_now == `EIB_IDX_IRQ_STAT);

        // Address phase; zero wait states, always OKAY
        s_d.hreadyout = 1'b1;
        s_d.hresp     = 1'b0;
        s_d.ap_write  = ap_take & hwrite;
        if (ap_take) begin
            s_d.ap_idx = ap_idx_now;
        end
        if (ap_take && !hwrite) begin
            s_d.rdata = {24'h000000, read_byte(ap_idx_now, s_q)};
        end

        // Data phase of a write
        if (s_q.ap_write) begin
            case (s_q.ap_idx)
                `EIB_IDX_POLICY: begin
                    s_d.auto_clear = wbyte[`EIB_POL_AUTOCLR_BIT];
                    s_d.err_sel    = wbyte[`EIB_POL_SEL_LSB +: 2];
                end
                `EIB_IDX_SRC_FIRST:  s_d.pair_a.src = wbyte[`EIB_ADDR_LSB +: 7];
                `EIB_IDX_DST_FIRST:  s_d.pair_a.dst = wbyte[`EIB_ADDR_LSB +: 7];
                `EIB_IDX_SRC_SECOND: s_d.pair_b.src = wbyte[`EIB_ADDR_LSB +: 7];
                `EIB_IDX_DST_SECOND: s_d.pair_b.dst = wbyte[`EIB_ADDR_LSB +: 7];
                `EIB_IDX_BRIDGE: begin
                    s_d.bridge.local_ack = wbyte[`EIB_BR_LOCACK_BIT];
                    s_d.bridge.sh_sel    = wbyte[`EIB_BR_SH_LSB +: 2];
                    s_d.bridge.rate_sel  = wbyte[`EIB_BR_RATE_LSB +: 3];
                end
                `EIB_IDX_DET_LIMIT: s_d.det_lim  = wbyte;
                `EIB_IDX_COR_LIMIT: s_d.cor_lim  = wbyte;
                `EIB_IDX_IRQ_MASK:  s_d.irq_mask = wbyte[1:0];
                default: ;
            endcase
        end

        // Counters are read-only; the timed clear beats a same-cycle event
        if (judge_clear) begin
            s_d.det_cnt = 8'h00;
            s_d.cor_cnt = 8'h00;
        end else begin
            if (det_err_evt && s_q.det_cnt != CNT_MAX) begin
                s_d.det_cnt = s_q.det_cnt + 8'h01;
            end
            if (cor_err_evt && s_q.cor_cnt != CNT_MAX) begin
                s_d.cor_cnt = s_q.cor_cnt + 8'h01;
            end
        end

        // Sticky events: error rise and automatic clear; set beats read-clear
        s_d.err_prev = judge_err;
        irq_evt      = {judge_clear, judge_err & ~s_q.err_prev};
        s_d.irq_stat = (stat_rd ? 2'h0 : s_q.irq_stat) | irq_evt;
        s_d.irq      = |(s_d.irq_stat & s_q.irq_mask);

        // Bridge outputs
        s_d.slave_ack = fwd_chan_up | s_q.bridge.local_ack;
        {s_d.setup_cyc, s_d.hold_cyc} = sh_cycles(s_q.bridge.sh_sel);
        s_d.rate_sel  = s_q.bridge.rate_sel;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= '{
                auto_clear: `EIB_RST_AUTOCLR,
                err_sel:    `EIB_RST_SEL,
                pair_a:     '{src: `EIB_RST_ADDR, dst: `EIB_RST_ADDR},
                pair_b:     '{src: `EIB_RST_ADDR, dst: `EIB_RST_ADDR},
                bridge:     '{local_ack: `EIB_RST_LOCACK, sh_sel: `EIB_RST_SH,
                              rate_sel: `EIB_RST_RATE},
                det_lim:    `EIB_RST_BYTE,
                cor_lim:    `EIB_RST_BYTE,
                det_cnt:    `EIB_RST_BYTE,
                cor_cnt:    `EIB_RST_BYTE,
                irq_stat:   2'h0,
                irq_mask:   2'h0,
                irq:        1'b0,
                err_prev:   1'b0,
                ap_write:   1'b0,
                ap_idx:     8'h00,
                rdata:      32'h00000000,
                hreadyout:  1'b1,
                hresp:      1'b0,
                slave_ack:  `EIB_RST_LOCACK,
                setup_cyc:  7'(`EIB_NS_UP(`EIB_SH1_SETUP_NS)),
                hold_cyc:   7'(`EIB_NS_UP(`EIB_SH1_HOLD_NS)),
                rate_sel:   `EIB_RST_RATE
            };
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata              = s_q.rdata;
    assign hreadyout           = s_q.hreadyout;
    assign hresp               = s_q.hresp;
    assign err_out             = judge_err;
    assign irq                 = s_q.irq;
    assign fwd_out_valid       = xl_out.valid;
    assign fwd_out_hit         = xl_out.hit;
    assign fwd_out_addr        = xl_out.addr;
    assign slave_ack_allow     = s_q.slave_ack;
    assign slave_setup_cyc     = s_q.setup_cyc;
    assign slave_hold_cyc      = s_q.hold_cyc;
    assign master_bit_rate_sel = s_q.rate_sel;

endmodule

`default_nettype wire

// File: core/eib_xlate.sv
// Slave address translator.
// Assumes at most one request per cycle.
`include "eib_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module eib_xlate
    import eib_pkg::*;
(
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            srst,
    // Programmed pairs
    input  wire eib_xlate_pair_t pair_a,
    input  wire eib_xlate_pair_t pair_b,
    // Request in
    input  wire logic            req_valid,
    input  wire logic [6:0]      req_addr,
    // Result out
    output eib_xlate_out_t       out_q
);

    function automatic logic addr_match(input logic [6:0] a, input eib_xlate_pair_t p);
        addr_match = (a == p.src);
    endfunction

    eib_xlate_pair_t pairs [2];
    logic [1:0]      hits;
    eib_xlate_out_t  s_q;
    eib_xlate_out_t  s_d;

    assign pairs[0] = pair_a;
    assign pairs[1] = pair_b;

    for (genvar i = 0; i < 2; i++) begin : g_pair
        assign hits[i] = addr_match(req_addr, pairs[i]);
    end

    always_comb begin
        s_d       = s_q;
        s_d.valid = req_valid;
        s_d.hit   = req_valid & (|hits);
        // First pair wins when both match
        if (hits[0]) begin
            s_d.addr = pair_a.dst;
        end else if (hits[1]) begin
            s_d.addr = pair_b.dst;
        end else begin
            s_d.addr = req_addr;
        end
        if (!req_valid) begin
            s_d.addr = s_q.addr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= '{valid: 1'b0, hit: 1'b0, addr: 7'h00};
        end else begin
            s_q <= s_d;
        end
    end

    assign out_q = s_q;

endmodule

`default_nettype wire

// File: sim/eib_ahb_master.sv
// Control-channel master model.
// Assumes hready is the slave's hreadyout.
`timescale 1ns/100ps
`default_nettype none

module eib_ahb_master (
    // Clock
    input  wire logic        ref_clk,
    // AHB-Lite master
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    initial begin
        hsel   = 1'b1;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // Released lines get junk
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd);
        @(posedge ref_clk);
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        haddr  <= ~haddr;
        hwdata <= w ? {24'h0, wd} : ~hwdata;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
endmodule
`default_nettype wire

// File: sim/eib_regs_bench.sv
// Self-checking bench.
// Assumes the master model and checker alongside.
`timescale 1ns/100ps
`default_nettype none

module eib_regs_bench;
    logic        ref_clk, srst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, master_bit_rate_sel;
    logic        det_err_evt, cor_err_evt, err_out, irq, fwd_chan_up, slave_ack_allow;
    logic        fwd_req_valid, fwd_out_valid, fwd_out_hit;
    logic [6:0]  fwd_req_addr, fwd_out_addr, slave_setup_cyc, slave_hold_cyc;
    logic [7:0]  bv;
    logic [7:0]  ridx [12] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0F, 8'h10,
                              8'h11, 8'h12, 8'h20, 8'h21};
    int          sun [4] = '{352, 469, 938, 1046};
    int          hon [4] = '{117, 234, 352, 469};
    int          fails, checks, n;

    eib_ahb_master mst_u (.ref_clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

    eib_regs dut_u (.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .det_err_evt(det_err_evt),
        .cor_err_evt(cor_err_evt), .err_out(err_out), .irq(irq),
        .fwd_req_valid(fwd_req_valid), .fwd_req_addr(fwd_req_addr),
        .fwd_out_valid(fwd_out_valid), .fwd_out_hit(fwd_out_hit), .fwd_out_addr(fwd_out_addr),
        .fwd_chan_up(fwd_chan_up), .slave_ack_allow(slave_ack_allow),
        .slave_setup_cyc(slave_setup_cyc), .slave_hold_cyc(slave_hold_cyc),
        .master_bit_rate_sel(master_bit_rate_sel));

    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic flag(input logic got, input logic exp, input string what);
        check({31'h0, got}, {31'h0, exp}, what);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        mst_u.xfer(1'b1, idx, d, unused);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] v;
        mst_u.xfer(1'b0, idx, 8'h00, v);
        check(v, exp, what);
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    // One-cycle error pulses
    task automatic pulse(input logic det, input int k);
        repeat (k) begin
            @(posedge ref_clk);
            det_err_evt <= det;
            cor_err_evt <= !det;
            @(posedge ref_clk);
            det_err_evt <= 1'b0;
            cor_err_evt <= 1'b0;
        end
        settle(3);
    endtask

    task automatic fwd(input logic [6:0] a, input logic hit, input logic [6:0] exp);
        @(posedge ref_clk);
        fwd_req_valid <= 1'b1;
        fwd_req_addr  <= a;
        @(posedge ref_clk);
        fwd_req_valid <= 1'b0;
        fwd_req_addr  <= ~a;
        #1;
        check({23'h0, fwd_out_valid, fwd_out_hit, fwd_out_addr}, {23'h0, 1'b1, hit, exp}, "xlate");
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Whole run is under a thousand cycles
    initial begin
        #200000;
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        fails = 0;
        checks = 0;
        srst = 1'b1;
        det_err_evt = 1'b0;
        cor_err_evt = 1'b0;
        fwd_req_valid = 1'b0;
        fwd_req_addr = 7'h00;
        fwd_chan_up = 1'b0;
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        foreach (ridx[i]) rd_chk(ridx[i], (ridx[i] == 8'h0D) ? 32'hB4 : 32'h0, "reset");
        wr(8'h0E, 8'hFF);
        rd_chk(8'h0E, 32'h0, "unmapped");
        $display("test reset done");

        wr(8'h09, 8'h55);
        wr(8'h0A, 8'h22);
        wr(8'h0B, 8'h31);
        wr(8'h0C, 8'h7E);
        rd_chk(8'h09, 32'h54, "src first");
        rd_chk(8'h0A, 32'h22, "dst first");
        rd_chk(8'h0B, 32'h30, "src second");
        rd_chk(8'h0C, 32'h7E, "dst second");
        fwd(7'h2A, 1'b1, 7'h11);
        fwd(7'h18, 1'b1, 7'h3F);
        fwd(7'h05, 1'b0, 7'h05);
        $display("test translate done");

        // Channel down: ack follows local bit
        for (int i = 0; i < 8; i++) begin
            bv = {i[0], i[1:0], i[2:0], 2'b00};
            wr(8'h0D, bv);
            rd_chk(8'h0D, {24'h0, bv}, "bridge readback");
            settle(1);
            check({14'h0, slave_setup_cyc, slave_hold_cyc, master_bit_rate_sel, slave_ack_allow},
                {14'h0, 7'((sun[i % 4] * 100 + 999) / 1000), 7'((hon[i % 4] * 100 + 999) / 1000),
                i[2:0], i[0]}, "bridge fields");
        end
        wr(8'h0D, 8'h34);
        @(posedge ref_clk);
        fwd_chan_up <= 1'b1;
        settle(2);
        flag(slave_ack_allow, 1'b1, "channel up");
        $display("test bridge done");

        wr(8'h0F, 8'h02);
        wr(8'h11, 8'h01);
        pulse(1'b1, 3);
        rd_chk(8'h10, 32'h3, "det count");
        wr(8'h10, 8'h00);
        rd_chk(8'h10, 32'h3, "count read only");
        flag(err_out, 1'b1, "sel 00 over");
        wr(8'h08, 8'h01);
        settle(2);
        flag(err_out, 1'b0, "sel 01 idle");
        pulse(1'b0, 1);
        flag(err_out, 1'b0, "sel 01 equal");
        pulse(1'b0, 1);
        flag(err_out, 1'b1, "sel 01 over");
        for (int s = 2; s < 4; s++) begin
            wr(8'h08, 8'(s));
            wr(8'h0F, 8'hFF);
            settle(2);
            flag(err_out, 1'b1, "either cor");
            wr(8'h11, 8'hFF);
            settle(2);
            flag(err_out, 1'b0, "either none");
            wr(8'h0F, 8'h02);
            settle(2);
            flag(err_out, 1'b1, "either det");
            wr(8'h11, 8'h01);
        end
        wr(8'h08, 8'h00);
        settle(200);
        rd_chk(8'h10, 32'h3, "no clear det");
        rd_chk(8'h12, 32'h2, "no clear cor");
        flag(err_out, 1'b1, "err kept");
        flag(irq, 1'b0, "masked");
        rd_chk(8'h20, 32'h1, "status rise");
        rd_chk(8'h20, 32'h0, "status cleared");
        $display("test error policy done");

        wr(8'h0F, 8'hFF);
        wr(8'h08, 8'h04);
        wr(8'h0F, 8'h02);
        n = 0;
        while (err_out !== 1'b1 && n < 20) begin
            settle(1);
            n++;
        end
        n = 0;
        while (err_out === 1'b1 && n < 300) begin
            settle(1);
            n++;
        end
        // Wait, clear pulse, then drop
        check(n, 102, "auto clear time");
        rd_chk(8'h10, 32'h0, "det cleared");
        rd_chk(8'h12, 32'h0, "cor cleared");
        flag(irq, 1'b0, "masked pending");
        wr(8'h21, 8'h03);
        settle(1);
        flag(irq, 1'b1, "unmasked");
        rd_chk(8'h20, 32'h3, "status both");
        settle(1);
        flag(irq, 1'b0, "irq cleared");
        $display("test auto clear done");
        complete_run();
    end
endmodule
`default_nettype wire

// File: sim/eib_regs_props.sv
// Checker bound to the register block.
// Assumes single zero-wait word transfers.
`timescale 1ns/100ps
`default_nettype none

module eib_regs_props (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Bridge
    input wire logic        fwd_req_valid,
    input wire logic [6:0]  fwd_req_addr,
    input wire logic        fwd_out_valid,
    input wire logic        fwd_out_hit,
    input wire logic [6:0]  fwd_out_addr,
    input wire logic        fwd_chan_up,
    input wire logic        slave_ack_allow,
    input wire logic [6:0]  slave_setup_cyc,
    input wire logic [6:0]  slave_hold_cyc,
    input wire logic [2:0]  master_bit_rate_sel
);
    logic       rd_q;
    logic [7:0] idx_q;

    // Read data phase tracker
    always_ff @(posedge ref_clk) begin
        rd_q  <= !srst && hsel && htrans[1] && hready && !hwrite;
        idx_q <= haddr[9:2];
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    AST_BUS_OKAY: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus answer not zero-wait OKAY");
    AST_BYTE_WIDE: assert property (hrdata[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    AST_XL_BIT0: assert property (rd_q && idx_q inside {[8'h09:8'h0C]} |-> !hrdata[0])
        else $error("translation bit 0 not zero");
    AST_UNMAPPED: assert property (rd_q && !(idx_q inside {[8'h08:8'h0D], [8'h0F:8'h12],
        8'h20, 8'h21}) |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_ACK_UP: assert property (fwd_chan_up |=> slave_ack_allow)
        else $error("acknowledge refused with channel up");
    AST_SH_PAIR: assert property ({slave_setup_cyc, slave_hold_cyc} inside {{7'h24, 7'h0C},
        {7'h2F, 7'h18}, {7'h5E, 7'h24}, {7'h69, 7'h2F}})
        else $error("setup and hold not a legal pair");
    AST_XL_VALID: assert property (fwd_req_valid |=> fwd_out_valid)
        else $error("translation answer missing");
    AST_XL_PASS: assert property (fwd_req_valid ##1 !fwd_out_hit |->
        fwd_out_addr == $past(fwd_req_addr))
        else $error("missed address not passed through");
    AST_RST_VALUES: assert property ($fell(srst) |-> master_bit_rate_sel == 3'h5 &&
        slave_setup_cyc == 7'h2F && slave_hold_cyc == 7'h18 && slave_ack_allow)
        else $error("bridge outputs wrong after reset");

    COV_HIT: cover property (fwd_out_valid && fwd_out_hit);
    COV_STATUS: cover property (rd_q && idx_q == 8'h20 && hrdata[1:0] == 2'h3);
    COV_NO_ACK: cover property ($fell(slave_ack_allow));
endmodule

bind eib_regs eib_regs_props chk_u (.*);
`default_nettype wire
